/* cpo_host.sv */
// host model issuing byte writes and reads
`timescale 1ns/1ns
`default_nettype none
module cpo_host
    import cpo_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    output var cpo_pkg::cpo_acc_s acc
);
    initial acc = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        acc <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        acc.wr <= 1'b0;
        // inverted so stale data never looks valid
        acc.wdata <= ~d;
        @(negedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        acc.addr <= a;
        repeat (2) @(posedge clk);
        d = rdata;
        acc.rd_done <= 1'b1;
        @(posedge clk);
        acc.rd_done <= 1'b0;
    endtask : rd
endmodule : cpo_host
`default_nettype wire

/* cpo_pkg.sv */
// package: offsets, field layout, reset values and timing for the protection option register
package cpo_pkg;
    localparam logic [7:0] CPO_ADDR_LO = 8'h3C;
    localparam logic [7:0] CPO_ADDR_HI = 8'h3D;
    localparam logic [15:0] CPO_RESET = 16'h0048;
    localparam logic [7:0] CPO_RETRY_ADDR = 8'h37;
    localparam int CPO_RETRY_DIS_BIT = 10;
    // high byte field positions
    localparam int CPO_UV_LSB = 13;
    localparam int CPO_DITHER_LSB = 11;
    localparam int CPO_DROOP_EN_BIT = 9;
    localparam int CPO_DROOP_FLAG_BIT = 8;
    // low byte field positions
    localparam int CPO_FILT_LSB = 6;
    localparam int CPO_RATIO_LSB = 3;
    localparam int CPO_DCH_EN_BIT = 2;
    localparam int CPO_DCH_FLAG_BIT = 1;
    localparam int CPO_PASS_BIT = 0;
    // bits the host may write
    localparam logic [15:0] CPO_WR_MASK = 16'hFEFC;
    // restart policy, clock rate and dither-off code
    localparam int CPO_RETRY_LIMIT = 7;
    localparam logic [2:0] CPO_RETRY_LIMIT_W = 3'h7;
    localparam longint CPO_CLK_HZ = 125000000;
    localparam longint CPO_WINDOW_S = 90;
    localparam longint CPO_WINDOW_CYC = CPO_WINDOW_S * CPO_CLK_HZ;
    localparam logic [1:0] CPO_DITHER_OFF = 2'h0;

    typedef struct packed {
        logic wr;
        logic rd_done;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cpo_acc_s;

    typedef struct packed {
        logic [2:0] uv_level;
        logic [1:0] dither;
        logic droop_alert_en;
        logic [1:0] filter_sel;
        logic [2:0] ratio_sel;
        logic dch_alert_en;
    } cpo_cfg_s;
endpackage : cpo_pkg

/* cpo_regs.sv */
// protection profile option register with latched status and restart control
`timescale 1ns/1ns
`default_nettype none
// Function
// - the 16-bit register sits at a high/low byte address pair and resets to 0x0048.
// - high bits 7:5 pick the undervoltage trip from 2.4 V to 8.0 V in 0.8 V steps, default 000b.
// - after an undervoltage trip the converter retries and is latched off after 7 failures in 90 s.
// - the restart sequence is suppressed while bit 10 of register 0x37 is one.
// - high bits 4:3 pick the dither spread: off, 2 %, 4 %, 6 %.
// - high bit 1 enables the input-droop alert contribution, default off.
// - low bits 7:6 pick the limit-2 deglitch time 100 us, 1.6 ms, 6 ms, 12 ms, default 01b.
// - low bits 5:3 pick limit 2 as a ratio of limit 1, 125 % at 000b, default 001b.
// - low bit 2 enables the limit-2 alert contribution, default off.
// - read-only low bit 1 flags that limit 2 triggered, held until the host reads it.
// - read-only low bit 0 shows pass-through operation.
module cpo_regs
    import cpo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cpo_pkg::cpo_acc_s acc,
    output logic [7:0] rdata,
    input wire logic retry_disable_in,
    input wire logic input_droop_event,
    input wire logic discharge_limit2_event,
    input wire logic passthrough_operation,
    input wire logic undervoltage_trip,
    input wire logic restart_ok,
    output cpo_pkg::cpo_cfg_s cfg,
    output logic restart_req,
    output logic converter_latched_off,
    output logic dither_on
);
    import cpo_pkg::*;

    logic [15:0] ctl_q;
    localparam int WIN_W = $clog2(CPO_WINDOW_CYC + 1);
    localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(CPO_WINDOW_CYC - 1);
    localparam int N_FLAGS = 2;

    typedef enum logic [2:0] {
        CPO_RS_IDLE = 3'b001,
        CPO_RS_WINDOW = 3'b010,
        CPO_RS_OFF = 3'b100
    } cpo_retry_e;

    // flag entry 0 is the droop flag (high byte), entry 1 the limit-2 flag (low byte)
    logic [N_FLAGS-1:0] flag_set;
    logic [N_FLAGS-1:0] flag_clr;
    logic [N_FLAGS-1:0] flag_q;
    logic droop_flag_q;
    logic dch_flag_q;
    logic [2:0] pass_sync_q;
    logic pass_q;
    logic [2:0] fails_q;
    logic [WIN_W-1:0] win_q;
    cpo_retry_e state_q;
    logic win_open;
    logic trip_ok;
    logic req_q;
    logic [7:0] rdata_q;

    // writable fields; read-only bits never stored here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_q <= CPO_RESET;
        end else if (acc.wr && acc.addr == CPO_ADDR_HI) begin
            ctl_q[15:8] <= acc.wdata & CPO_WR_MASK[15:8];
        end else if (acc.wr && acc.addr == CPO_ADDR_LO) begin
            ctl_q[7:0] <= acc.wdata & CPO_WR_MASK[7:0];
        end
    end

    assign flag_set = {discharge_limit2_event, input_droop_event};
    assign flag_clr[0] = acc.rd_done && (acc.addr == CPO_ADDR_HI);
    assign flag_clr[1] = acc.rd_done && (acc.addr == CPO_ADDR_LO);

    // set beats the read-completion clear so an event in the clearing cycle is kept
    for (genvar gi = 0; gi < N_FLAGS; gi++) begin : g_flag
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                flag_q[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
                flag_q[gi] <= 1'b1;
            end else if (flag_clr[gi]) begin
                flag_q[gi] <= 1'b0;
            end
        end
    end

    assign droop_flag_q = flag_q[0];
    assign dch_flag_q = flag_q[1];

    // pass-through level arrives from the analog side; change taken once stages 2 and 3 agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pass_sync_q <= 3'h0;
            pass_q <= 1'b0;
        end else begin
            pass_sync_q <= {pass_sync_q[1:0], passthrough_operation};
            if (pass_sync_q[2] == pass_sync_q[1]) begin
                pass_q <= pass_sync_q[2];
            end
        end
    end

    // a trip arriving on the very cycle the window runs out opens a fresh window
    assign win_open = (state_q == CPO_RS_WINDOW) && (win_q != '0);
    assign trip_ok = undervoltage_trip && !retry_disable_in;

    // restart policy: window opens at first failure; seventh failure inside it latches off
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= CPO_RS_IDLE;
            fails_q <= 3'h0;
            win_q <= '0;
            req_q <= 1'b0;
        end else begin
            req_q <= 1'b0;
            case (state_q)
                CPO_RS_IDLE: begin
                    if (trip_ok && !restart_ok) begin
                        req_q <= 1'b1;
                        state_q <= CPO_RS_WINDOW;
                        win_q <= WIN_LOAD;
                        fails_q <= 3'h1;
                    end
                end
                CPO_RS_WINDOW: begin
                    if (restart_ok) begin
                        state_q <= CPO_RS_IDLE;
                        fails_q <= 3'h0;
                    end else if (trip_ok && !win_open) begin
                        req_q <= 1'b1;
                        win_q <= WIN_LOAD;
                        fails_q <= 3'h1;
                    end else if (trip_ok && fails_q == CPO_RETRY_LIMIT_W - 3'h1) begin
                        state_q <= CPO_RS_OFF;
                        fails_q <= CPO_RETRY_LIMIT_W;
                    end else if (trip_ok) begin
                        req_q <= 1'b1;
                        fails_q <= fails_q + 3'h1;
                        win_q <= win_q - 1'b1;
                    end else if (!win_open) begin
                        state_q <= CPO_RS_IDLE;
                        fails_q <= 3'h0;
                    end else begin
                        win_q <= win_q - 1'b1;
                    end
                end
                CPO_RS_OFF: begin
                    // only reset leaves latch-off
                    state_q <= CPO_RS_OFF;
                end
                default: begin
                    state_q <= CPO_RS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (acc.addr == CPO_ADDR_HI) begin
            rdata_q <= {ctl_q[15:9], droop_flag_q};
        end else if (acc.addr == CPO_ADDR_LO) begin
            rdata_q <= {ctl_q[7:2], dch_flag_q, pass_q};
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata = rdata_q;
    assign cfg.uv_level = ctl_q[CPO_UV_LSB +: 3];
    assign cfg.dither = ctl_q[CPO_DITHER_LSB +: 2];
    assign cfg.droop_alert_en = ctl_q[CPO_DROOP_EN_BIT];
    assign cfg.filter_sel = ctl_q[CPO_FILT_LSB +: 2];
    assign cfg.ratio_sel = ctl_q[CPO_RATIO_LSB +: 3];
    assign cfg.dch_alert_en = ctl_q[CPO_DCH_EN_BIT];
    assign dither_on = (ctl_q[CPO_DITHER_LSB +: 2] != CPO_DITHER_OFF);
    assign restart_req = req_q;
    assign converter_latched_off = (state_q == CPO_RS_OFF);
endmodule : cpo_regs
`default_nettype wire

/* cpo_regs_asserts.sv */
// checker for the protection option register ports
`timescale 1ns/1ns
`default_nettype none
module cpo_regs_chk
    import cpo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire cpo_pkg::cpo_acc_s acc,
    input wire logic [7:0] rdata,
    input wire logic retry_disable_in,
    input wire logic input_droop_event,
    input wire logic undervoltage_trip,
    input wire cpo_pkg::cpo_cfg_s cfg,
    input wire logic restart_req,
    input wire logic converter_latched_off,
    input wire logic dither_on
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire logic wh = acc.wr && acc.addr == CPO_ADDR_HI;
    wire logic wl = acc.wr && acc.addr == CPO_ADDR_LO;
    AST_UNMAPPED: assert property (acc.addr != CPO_ADDR_HI && acc.addr != CPO_ADDR_LO
        |=> rdata == 8'h00) else $error("unmapped byte not zero");
    AST_UV: assert property (wh |=> cfg.uv_level == $past(acc.wdata[7:5]))
        else $error("uv level not written");
    AST_DITHER: assert property (dither_on == (cfg.dither != CPO_DITHER_OFF))
        else $error("dither_on wrong");
    AST_DROOP_EN: assert property (wh |=> cfg.droop_alert_en == $past(acc.wdata[1]))
        else $error("droop enable not written");
    AST_FILT: assert property (wl |=> cfg.filter_sel == $past(acc.wdata[7:6]))
        else $error("filter not written");
    AST_RATIO: assert property (wl |=> {cfg.ratio_sel, cfg.dch_alert_en} == $past(acc.wdata[5:2]))
        else $error("ratio or enable not written");
    AST_FLAG: assert property (input_droop_event ##1 acc.addr == CPO_ADDR_HI |=> rdata[0])
        else $error("droop flag lost");
    AST_NO_RETRY: assert property (undervoltage_trip && retry_disable_in |=> !restart_req)
        else $error("restart while suppressed");
    AST_LATCH: assert property (converter_latched_off |=> converter_latched_off[*3])
        else $error("latch-off released");
endmodule : cpo_regs_chk
`default_nettype wire

/* tb_cpo_regs.sv */
// testbench for the protection option register
`timescale 1ns/1ns
`default_nettype none
module tb_cpo_regs;
    import cpo_pkg::*;
    logic clk = 0, rst_n = 0, rdis = 0, req, off, dth;
    // event inputs: droop, limit2, trip, restart ok, pass-through
    logic [4:0] ev = '0;
    logic [7:0] rdata, d;
    cpo_acc_s acc;
    cpo_cfg_s cfg;
    int err_total = 0, n_tests = 0;
    cpo_host i_host (.clk, .rdata, .acc);
    cpo_regs i_dut (.clk, .rst_n, .acc, .rdata, .retry_disable_in(rdis),
        .input_droop_event(ev[0]), .discharge_limit2_event(ev[1]),
        .passthrough_operation(ev[4]), .undervoltage_trip(ev[2]), .restart_ok(ev[3]),
        .cfg, .restart_req(req), .converter_latched_off(off), .dither_on(dth));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
    endtask : pulse
    task automatic t_fields;
        i_host.rd(CPO_ADDR_LO, d);
        chk(d, 8'h48);
        i_host.rd(CPO_ADDR_HI, d);
        chk(d, 8'h00);
        for (int i = 0; i < 4; i++) begin
            i_host.wr(CPO_ADDR_HI, 8'hE0 | (8'(i) << 3));
            chk(8'(dth), 8'(i != 0));
        end
        chk(8'(cfg.uv_level), 8'h07);
        i_host.wr(CPO_ADDR_HI, 8'hFF);
        i_host.rd(CPO_ADDR_HI, d);
        chk(d, 8'hFE);
        i_host.wr(CPO_ADDR_LO, 8'hFF);
        i_host.rd(CPO_ADDR_LO, d);
        chk(d, 8'hFC);
    endtask : t_fields
    task automatic t_flags;
        pulse(0);
        i_host.rd(CPO_ADDR_HI, d);
        chk(d & 8'h01, 8'h01);
        fork
            i_host.rd(CPO_ADDR_HI, d);
            begin
                repeat (2) @(posedge clk);
                pulse(0);
            end
        join
        chk(d & 8'h01, 8'h00);
        i_host.rd(CPO_ADDR_HI, d);
        chk(d & 8'h01, 8'h01);
        pulse(1);
        i_host.rd(CPO_ADDR_LO, d);
        chk(d & 8'h02, 8'h02);
        i_host.rd(CPO_ADDR_LO, d);
        chk(d & 8'h02, 8'h00);
    endtask : t_flags
    task automatic t_retry;
        @(posedge clk);
        rdis <= 1'b1;
        pulse(2);
        @(negedge clk);
        chk(8'(req), 8'h00);
        @(posedge clk);
        rdis <= 1'b0;
        pulse(2);
        @(negedge clk);
        chk(8'(req), 8'h01);
        repeat (5) pulse(2);
        pulse(3);
        repeat (6) pulse(2);
        @(negedge clk);
        chk(8'(off), 8'h00);
        pulse(2);
        @(negedge clk);
        chk(8'(off), 8'h01);
    endtask : t_retry
    task automatic conclude;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_fields;
        t_flags;
        t_retry;
        @(posedge clk);
        ev[4] <= 1'b1;
        repeat (8) @(posedge clk);
        i_host.rd(CPO_ADDR_LO, d);
        chk(d & 8'h01, 8'h01);
        conclude;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        conclude;
    end
endmodule : tb_cpo_regs
bind cpo_regs cpo_regs_chk i_chk (.clk, .rst_n, .acc, .rdata, .retry_disable_in,
    .input_droop_event, .undervoltage_trip, .cfg, .restart_req, .converter_latched_off,
    .dither_on);
`default_nettype wire
